// ==== wic_regs.vh ====
// Purpose: Register map, field layout and timing constants of the wake input block
// Assumes: 32-bit Avalon-MM data, byte addresses, one register per aligned word
// Notes:   Included by the design file by its bare name
`ifndef WIC_REGS_VH
`define WIC_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define WIC_OFS_PULL     5'h00
`define WIC_OFS_FILTER   5'h04
`define WIC_OFS_WAKE_EN  5'h08
`define WIC_OFS_MEAS     5'h0C
`define WIC_OFS_MODE     5'h10
`define WIC_OFS_STATUS   5'h14
`define WIC_OFS_MASK     5'h18
`define WIC_OFS_LEVEL    5'h1C

// ----------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------
// Two-bit code per input: input n uses bits 2n+1 (hi) and 2n (lo)
`define WIC_PULL_RST     6'h00
`define WIC_FILT_RST     6'h00
`define WIC_WEN_RST      3'h0
// Status: bits 2:0 wake source flags, bit 3 command fault
`define WIC_ST_FAULT     3
`define WIC_MASK_RST     4'h0

// ----------------------------------------------------------------
// Pull and filter codes
// ----------------------------------------------------------------
`define WIC_PULL_NONE    2'h0
`define WIC_PULL_DOWN    2'h1
`define WIC_PULL_UP      2'h2
`define WIC_PULL_AUTO    2'h3
`define WIC_FLT_STAT16   2'h0
`define WIC_FLT_STAT64   2'h1
`define WIC_FLT_CYC_A    2'h2
`define WIC_FLT_CYC_B    2'h3

// ----------------------------------------------------------------
// Operating modes
// ----------------------------------------------------------------
`define WIC_MODE_NORMAL  2'h0
`define WIC_MODE_STOP    2'h1
`define WIC_MODE_SLEEP   2'h2
`define WIC_MODE_RESTART 2'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define WIC_CLK_PERIOD_NS 100
`define WIC_FILT_SHORT_NS 16000
`define WIC_FILT_LONG_NS  64000

`endif

// ==== wic_core.v ====
// Purpose: Wake input pull, filter and measurement routing control
// Assumes: SYS_CLK at 10 MHz, HV_IN are comparator outputs from pins
// Notes:   Cyclic timers are outside; their on-windows arrive as inputs
//
// Summary of operation
// - Code 00 enables no current source, reset default.
// - Code 01 pull-down, code 10 pull-up.
// - Code 11 pull follows sensed input level.
// - Filter 00 static 16us, 01 static 64us.
// - Filter 10/11 cyclic on timer A/B, 16us.
// - Reset: measurement off, sense switch open.
// - Switch closed only in normal mode with measurement.
// - Measurement disables pulls, gates first two inputs.
// - Writes accepted during measurement, effect ignored.
// - Measurement freezes flags and levels of inputs 0,1.
// - Sleep with only gated wake sources: fault, restart.
// - Wake only if level holds for filter time.
// - Both edges; interrupt normal/stop, wake from sleep.
//
// Chosen here: register access over Avalon-MM and the placing of the registers.

`include "wic_regs.vh"

module wic_core #(
    parameter N_IN = 3
) (
    input wire SYS_CLK,
    input wire NRST,
    input wire [4:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    output reg [31:0] AVS_READDATA,
    output reg AVS_WAITREQUEST,
    input wire [2:0] HV_IN,
    input wire TIMER_A_ON,
    input wire TIMER_B_ON,
    output reg [2:0] PULL_UP_EN,
    output reg [2:0] PULL_DOWN_EN,
    output reg SENSE_SWITCH_CLOSE,
    output reg IRQ
);

    // ----------------------------------------------------------------
    // Timing counts
    // ----------------------------------------------------------------
    // Nominal filter times, rounded up to whole clock cycles
    localparam integer FILT_SHORT_INT =
        (`WIC_FILT_SHORT_NS + `WIC_CLK_PERIOD_NS - 1) / `WIC_CLK_PERIOD_NS;
    localparam integer FILT_LONG_INT =
        (`WIC_FILT_LONG_NS + `WIC_CLK_PERIOD_NS - 1) / `WIC_CLK_PERIOD_NS;
    // Both counts fit 10 bits; the cut drops zeros
    localparam [9:0] FILT_SHORT_CYC = FILT_SHORT_INT[9:0];
    localparam [9:0] FILT_LONG_CYC = FILT_LONG_INT[9:0];

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    // Shared by filter and pull logic
    // Pick the two-bit code of one input from a packed field
    function [1:0] code_of;
        input [5:0] field;
        input integer idx;
        begin
            code_of = field[2*idx +: 2];
        end
    endfunction

    // Input is masked off while routed to the measurement path
    function is_gated;
        input meas;
        input integer idx;
        begin
            is_gated = meas && (idx < 2);
        end
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    reg [5:0] wake_pull_config_reg; // Stored pull codes
    reg [5:0] wake_filter_config_reg; // Stored filter codes
    reg [2:0] wake_enable_config_reg; // Wake source enables
    reg measure_route_enable_reg; // Measurement routing on
    reg [1:0] mode_reg; // Operating mode
    reg [1:0] mode_next;
    reg [3:0] status_reg; // Sticky flags, write one to clear
    reg [3:0] status_next;
    reg [3:0] mask_reg; // Interrupt mask, same layout
    reg [2:0] input_level_status_reg; // Filtered levels
    reg [2:0] level_next;
    reg [2:0] sync1_reg; // First synchroniser stage
    reg [2:0] sync2_reg; // Second stage
    reg [2:0] sync3_reg; // Third stage
    reg [2:0] sensed_reg; // Level once stages two and three agree
    reg [2:0] sensed_next;
    reg [9:0] filt_cnt_reg [0:2]; // Per-input filter counters
    reg [9:0] filt_cnt_next [0:2];
    reg [2:0] wake_evt; // One-cycle recognised edge
    reg [2:0] up_next;
    reg [2:0] down_next;
    // Filter scratch, one input at a time
    reg [1:0] code;
    reg [9:0] limit;
    reg active;
    integer i;

    // Bus decode
    // One access in flight at a time
    wire req = AVS_READ || AVS_WRITE;
    wire take = req && AVS_WAITREQUEST; // Request seen, answer next edge
    wire wr_now = AVS_WRITE && !AVS_WAITREQUEST; // Write takes effect
    wire wr_mode = wr_now && (AVS_ADDRESS == `WIC_OFS_MODE);
    wire wr_status = wr_now && (AVS_ADDRESS == `WIC_OFS_STATUS);

    // ----------------------------------------------------------------
    // Input synchroniser
    // ----------------------------------------------------------------
    // Three stages; a change counts once the last two agree
    // Only stage two reads stage one
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            sync3_reg <= 3'h0;
        end else begin
            sync1_reg <= HV_IN;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // ----------------------------------------------------------------
    // Filters and level tracking
    // ----------------------------------------------------------------
    // A crossing starts the count; crossing back restarts it
    always @* begin
        sensed_next = sensed_reg;
        level_next = input_level_status_reg;
        wake_evt = 3'h0;
        code = 2'h0;
        limit = FILT_SHORT_CYC;
        active = 1'b0;
        for (i = 0; i < N_IN; i = i + 1) begin
            // Counter rests at zero when idle
            filt_cnt_next[i] = 10'h000;
            if (sync2_reg[i] == sync3_reg[i]) begin
                sensed_next[i] = sync3_reg[i];
            end
            code = code_of(wake_filter_config_reg, i);
            // Only the static 64us code uses the long filter
            limit = (code == `WIC_FLT_STAT64) ? FILT_LONG_CYC : FILT_SHORT_CYC;
            // Static codes always listen; cyclic only in timer window
            // Window closing restarts cyclic count
            case (code)
                `WIC_FLT_STAT16: active = 1'b1;
                `WIC_FLT_STAT64: active = 1'b1;
                `WIC_FLT_CYC_A: active = TIMER_A_ON;
                `WIC_FLT_CYC_B: active = TIMER_B_ON;
                default: active = 1'b0;
            endcase
            if (is_gated(measure_route_enable_reg, i)) begin
                // Gated inputs freeze level and raise nothing
                filt_cnt_next[i] = 10'h000;
            end else if (active && sensed_reg[i] != input_level_status_reg[i]) begin
                if (filt_cnt_reg[i] == limit - 10'h001) begin
                    // Held across the whole interval: recognised
                    level_next[i] = sensed_reg[i];
                    wake_evt[i] = 1'b1;
                end else begin
                    filt_cnt_next[i] = filt_cnt_reg[i] + 10'h001;
                end
            end
        end
    end

    // Counters and levels
    // Gated inputs keep their last level
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            sensed_reg <= 3'h0;
            input_level_status_reg <= 3'h0;
            for (i = 0; i < N_IN; i = i + 1) begin
                filt_cnt_reg[i] <= 10'h000;
            end
        end else begin
            sensed_reg <= sensed_next;
            input_level_status_reg <= level_next;
            for (i = 0; i < N_IN; i = i + 1) begin
                filt_cnt_reg[i] <= filt_cnt_next[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // Mode and status
    // ----------------------------------------------------------------
    // Sleep request with only gated sources enabled is refused
    // Flags are set in every mode
    always @* begin
        mode_next = mode_reg;
        status_next = status_reg;
        if (wr_status) begin
            status_next = status_reg & ~AVS_WRITEDATA[3:0];
        end
        // Mode write is a command
        if (wr_mode) begin
            if (AVS_WRITEDATA[1:0] == `WIC_MODE_SLEEP && measure_route_enable_reg
                && wake_enable_config_reg[1:0] != 2'h0
                && !wake_enable_config_reg[2]) begin
                status_next[`WIC_ST_FAULT] = 1'b1;
                mode_next = `WIC_MODE_RESTART;
            end else begin
                mode_next = AVS_WRITEDATA[1:0];
            end
        end
        // Events win over a clearing write in the same cycle
        status_next[2:0] = status_next[2:0] | (wake_evt & wake_enable_config_reg);
        // A recognised enabled edge wakes a sleeping device
        if (mode_reg == `WIC_MODE_SLEEP && (wake_evt & wake_enable_config_reg) != 3'h0) begin
            mode_next = `WIC_MODE_NORMAL;
        end
    end

    // Mode and status registers
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            mode_reg <= `WIC_MODE_NORMAL;
            status_reg <= 4'h0;
        end else begin
            mode_reg <= mode_next;
            status_reg <= status_next;
        end
    end

    // ----------------------------------------------------------------
    // Pull source selection
    // ----------------------------------------------------------------
    // Settings are read through the gate, never altered, so clearing
    // measurement brings them back the very next cycle
    // Code 00 leaves both sources off
    always @* begin
        up_next = 3'h0;
        down_next = 3'h0;
        for (i = 0; i < N_IN; i = i + 1) begin
            if (is_gated(measure_route_enable_reg, i)) begin
                up_next[i] = 1'b0;
                down_next[i] = 1'b0;
            end else begin
                // Stored code, input not gated
                case (code_of(wake_pull_config_reg, i))
                    `WIC_PULL_NONE: up_next[i] = 1'b0;
                    `WIC_PULL_DOWN: down_next[i] = 1'b1;
                    `WIC_PULL_UP: up_next[i] = 1'b1;
                    `WIC_PULL_AUTO: begin
                        // Follow the sensed level
                        up_next[i] = sensed_reg[i];
                        down_next[i] = !sensed_reg[i];
                    end
                    default: up_next[i] = 1'b0;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Output registers
    // ----------------------------------------------------------------
    // Switch uses next mode so it opens on the edge the mode leaves normal
    // IRQ follows next status
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            PULL_UP_EN <= 3'h0;
            PULL_DOWN_EN <= 3'h0;
            SENSE_SWITCH_CLOSE <= 1'b0;
            IRQ <= 1'b0;
        end else begin
            PULL_UP_EN <= up_next;
            PULL_DOWN_EN <= down_next;
            SENSE_SWITCH_CLOSE <= measure_route_enable_reg
                && (mode_next == `WIC_MODE_NORMAL);
            // Interrupt only while awake enough to serve it
            IRQ <= ((status_next & mask_reg) != 4'h0)
                && (mode_next == `WIC_MODE_NORMAL || mode_next == `WIC_MODE_STOP);
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    // Writes always land, even to gated inputs
    // Status and mode decoded above
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            wake_pull_config_reg <= `WIC_PULL_RST;
            wake_filter_config_reg <= `WIC_FILT_RST;
            wake_enable_config_reg <= `WIC_WEN_RST;
            measure_route_enable_reg <= 1'b0;
            mask_reg <= `WIC_MASK_RST;
        end else if (wr_now) begin
            case (AVS_ADDRESS)
                `WIC_OFS_PULL: wake_pull_config_reg <= AVS_WRITEDATA[5:0];
                `WIC_OFS_FILTER: wake_filter_config_reg <= AVS_WRITEDATA[5:0];
                `WIC_OFS_WAKE_EN: wake_enable_config_reg <= AVS_WRITEDATA[2:0];
                `WIC_OFS_MEAS: measure_route_enable_reg <= AVS_WRITEDATA[0];
                `WIC_OFS_MASK: mask_reg <= AVS_WRITEDATA[3:0];
                default: mask_reg <= mask_reg; // Unmapped or handled elsewhere
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Avalon-MM slave
    // ----------------------------------------------------------------
    // One wait state: waitrequest drops for one cycle after a request
    // is seen; read data is captured on that same edge. Costs one
    // cycle per access but keeps every bus output a flip-flop.
    // Master holds request until answer
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA <= 32'h0000_0000;
        end else begin
            // High again after the answer
            AVS_WAITREQUEST <= !take;
            if (take && AVS_READ) begin
                case (AVS_ADDRESS)
                    `WIC_OFS_PULL: AVS_READDATA <= {26'h000_0000, wake_pull_config_reg};
                    `WIC_OFS_FILTER: AVS_READDATA <= {26'h000_0000, wake_filter_config_reg};
                    `WIC_OFS_WAKE_EN: AVS_READDATA <= {29'h000_0000, wake_enable_config_reg};
                    `WIC_OFS_MEAS: AVS_READDATA <= {31'h0000_0000, measure_route_enable_reg};
                    `WIC_OFS_MODE: AVS_READDATA <= {30'h0000_0000, mode_reg};
                    `WIC_OFS_STATUS: AVS_READDATA <= {28'h000_0000, status_reg};
                    `WIC_OFS_MASK: AVS_READDATA <= {28'h000_0000, mask_reg};
                    `WIC_OFS_LEVEL: AVS_READDATA <= {29'h000_0000, input_level_status_reg};
                    default: AVS_READDATA <= 32'h0000_0000; // Unmapped reads zero
                endcase
            end
        end
    end

endmodule // wic_core

// ==== wic_checker.sv ====
// Purpose: Port-level assertions for the wake input block
// Assumes: A write lands on the edge where waitrequest is sampled low
// Notes:   Shadow copies hold only what software wrote, not derived state
`include "wic_regs.vh"
module wic_checker (
    input wire SYS_CLK,
    input wire NRST,
    input wire [4:0] AVS_ADDRESS,
    input wire AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    input wire AVS_WAITREQUEST,
    input wire [2:0] HV_IN,
    input wire [2:0] PULL_UP_EN,
    input wire [2:0] PULL_DOWN_EN,
    input wire SENSE_SWITCH_CLOSE,
    input wire IRQ
);
    // ------------------------------------------------------------
    // Shadow registers
    // ------------------------------------------------------------
    reg [5:0] pull_reg; // Pull codes as written
    reg meas_reg; // Measurement enable as written
    reg [1:0] mode_reg; // Last mode command
    reg [3:0] mask_reg; // Interrupt mask as written
    // Update on the same edge as the design's own registers
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            pull_reg <= 6'h00;
            meas_reg <= 1'b0;
            mode_reg <= 2'h0;
            mask_reg <= 4'h0;
        end else if (AVS_WRITE && !AVS_WAITREQUEST) begin
            case (AVS_ADDRESS)
                `WIC_OFS_PULL: pull_reg <= AVS_WRITEDATA[5:0];
                `WIC_OFS_MEAS: meas_reg <= AVS_WRITEDATA[0];
                `WIC_OFS_MODE: mode_reg <= AVS_WRITEDATA[1:0];
                `WIC_OFS_MASK: mask_reg <= AVS_WRITEDATA[3:0];
                default: ;
            endcase
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    a_reset_idle: assert property (
        $rose(NRST) |-> !SENSE_SWITCH_CLOSE && PULL_UP_EN == 3'h0 && PULL_DOWN_EN == 3'h0)
        else $error("outputs not idle after reset");
    // A stop or sleep command must open the switch on its own edge
    a_switch_normal: assert property (
        SENSE_SWITCH_CLOSE |-> mode_reg == `WIC_MODE_NORMAL && (meas_reg || $past(meas_reg)))
        else $error("sense switch closed outside normal measurement");
    a_meas_nopull: assert property (
        meas_reg && $past(meas_reg) |-> PULL_UP_EN[1:0] == 2'h0 && PULL_DOWN_EN[1:0] == 2'h0)
        else $error("pull active on gated input");
    a_code_none: assert property (
        (pull_reg[5:4] == 2'h0) [*3] |-> !PULL_UP_EN[2] && !PULL_DOWN_EN[2])
        else $error("current source with code none");
    a_code_up: assert property (
        (pull_reg[5:4] == 2'h2) [*3] |-> PULL_UP_EN[2] && !PULL_DOWN_EN[2])
        else $error("pull-up code not obeyed");
    a_code_down: assert property (
        (pull_reg[5:4] == 2'h1) [*3] |-> PULL_DOWN_EN[2] && !PULL_UP_EN[2])
        else $error("pull-down code not obeyed");
    // Eight cycles cover the three-stage synchroniser plus output register
    a_auto_high: assert property (
        (pull_reg[5:4] == 2'h3 && HV_IN[2]) [*8] |-> PULL_UP_EN[2] && !PULL_DOWN_EN[2])
        else $error("automatic pull does not follow high level");
    a_irq_masked: assert property (
        (mask_reg == 4'h0) [*2] |-> !IRQ)
        else $error("interrupt with all sources masked");
    c_switch: cover property (SENSE_SWITCH_CLOSE);
    c_irq: cover property ($rose(IRQ));
    c_auto: cover property (pull_reg[5:4] == 2'h3 && PULL_UP_EN[2]);
endmodule // wic_checker

// ==== wic_partner.sv ====
// Purpose: Far-side model: wake switches with contact bounce, timer windows
// Assumes: Bench commands levels and windows at the rising edge
// Notes:   Bounce is far shorter than any filter, so it must never wake
module wic_partner #(
    parameter int BOUNCE = 5
) (
    input wire sys_clk,
    input wire [2:0] level_cmd,
    input wire [1:0] timer_cmd,
    output logic [2:0] hv_in,
    output wire timer_a_on,
    output wire timer_b_on
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] last_reg = 3'h0; // Settled switch position
    logic [2:0] diff_reg = 3'h0; // Contacts still bouncing
    int bnc = 0; // Bounce cycles left
    // Each change chatters every cycle before it settles, too fast to pass the synchroniser
    always @(posedge sys_clk) begin
        if (level_cmd != last_reg) begin
            diff_reg <= level_cmd ^ last_reg;
            last_reg <= level_cmd;
            bnc <= BOUNCE;
        end else if (bnc != 0) begin
            bnc <= bnc - 1;
        end
        hv_in <= level_cmd ^ ((bnc % 2 == 1) ? diff_reg : 3'h0);
    end
    // Timer windows power the external circuit of a cyclic input
    assign timer_a_on = timer_cmd[0];
    assign timer_b_on = timer_cmd[1];
endmodule // wic_partner

// ==== testbench.sv ====
// Purpose: Self-checking bench of the wake input block against a model
// Assumes: One wait cycle per bus access, filters of 160 and 640 cycles
// Notes:   Model state lives in ints; level changes are entered by the tests
`include "wic_regs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic SYS_CLK = 1'b0;
    logic NRST = 1'b0;
    logic [4:0] AVS_ADDRESS = 5'h00;
    logic AVS_READ = 1'b0;
    logic AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
    wire [31:0] AVS_READDATA;
    wire AVS_WAITREQUEST;
    wire [2:0] HV_IN;
    wire TIMER_A_ON;
    wire TIMER_B_ON;
    wire [2:0] PULL_UP_EN;
    wire [2:0] PULL_DOWN_EN;
    wire SENSE_SWITCH_CLOSE;
    wire IRQ;
    logic [2:0] lvl = 3'h0; // Commanded switch levels
    logic [1:0] tmr = 2'h0; // Commanded timer windows
    int failures = 0;
    int checks = 0;
    int m_pull = 0, m_filt = 0, m_wen = 0, m_meas = 0;
    int m_mode = 0, m_st = 0, m_mask = 0, m_lvl = 0;
    always #50 SYS_CLK = ~SYS_CLK;
    wic_core #(.N_IN(3)) i_dut (.SYS_CLK(SYS_CLK), .NRST(NRST), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .HV_IN(HV_IN),
        .TIMER_A_ON(TIMER_A_ON), .TIMER_B_ON(TIMER_B_ON), .PULL_UP_EN(PULL_UP_EN),
        .PULL_DOWN_EN(PULL_DOWN_EN), .SENSE_SWITCH_CLOSE(SENSE_SWITCH_CLOSE), .IRQ(IRQ));
    wic_partner i_far (.sys_clk(SYS_CLK), .level_cmd(lvl), .timer_cmd(tmr), .hv_in(HV_IN),
        .timer_a_on(TIMER_A_ON), .timer_b_on(TIMER_B_ON));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // Hold the request until waitrequest is sampled low, then release
    task automatic bus(input bit w, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n = 0;
        @(posedge SYS_CLK);
        AVS_ADDRESS <= a;
        AVS_WRITE <= w;
        AVS_READ <= !w;
        AVS_WRITEDATA <= d;
        do begin
            @(posedge SYS_CLK);
            n++;
        end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
        q = AVS_READDATA;
        if (n >= 50) chk("bus answer", 32'h0000_0000, 32'h0000_0001);
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
    endtask
    // Write and mirror its effect in the model, refused sleep included
    task automatic wr(input logic [4:0] a, input int d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
        case (a)
            `WIC_OFS_PULL: m_pull = d & 63;
            `WIC_OFS_FILTER: m_filt = d & 63;
            `WIC_OFS_WAKE_EN: m_wen = d & 7;
            `WIC_OFS_MEAS: m_meas = d & 1;
            `WIC_OFS_MASK: m_mask = d & 15;
            `WIC_OFS_STATUS: m_st &= ~d;
            `WIC_OFS_MODE: begin
                if (d == 2 && m_meas == 1 && (m_wen & 3) != 0 && (m_wen & 4) == 0) begin
                    m_st |= 8;
                    m_mode = 3;
                end else m_mode = d & 3;
            end
            default: ;
        endcase
    endtask
    function automatic int mrd(input logic [4:0] a);
        case (a)
            `WIC_OFS_PULL: return m_pull;
            `WIC_OFS_FILTER: return m_filt;
            `WIC_OFS_WAKE_EN: return m_wen;
            `WIC_OFS_MEAS: return m_meas;
            `WIC_OFS_MODE: return m_mode;
            `WIC_OFS_STATUS: return m_st;
            `WIC_OFS_MASK: return m_mask;
            `WIC_OFS_LEVEL: return m_lvl;
            default: return 0;
        endcase
    endfunction
    task automatic rd(input logic [4:0] a);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        chk($sformatf("register %h", a), mrd(a), q);
    endtask
    function automatic logic [2:0] epull(input bit up);
        int c;
        epull = 3'h0;
        for (int i = 0; i < 3; i++) begin
            c = (m_pull >> (2 * i)) & 3;
            if (!(m_meas == 1 && i < 2))
                epull[i] = up ? (c == 2 || (c == 3 && lvl[i])) : (c == 1 || (c == 3 && !lvl[i]));
        end
    endfunction
    // Let a few edges settle, then compare the pull, switch and interrupt pins
    task automatic outs();
        repeat (6) @(posedge SYS_CLK);
        chk("pull up", epull(1'b1), PULL_UP_EN);
        chk("pull down", epull(1'b0), PULL_DOWN_EN);
        chk("switch", m_meas == 1 && m_mode == 0, SENSE_SWITCH_CLOSE);
        chk("irq", (m_st & m_mask) != 0 && m_mode < 2, IRQ);
    endtask
    // Third input: early read must see no change, late read must
    task automatic flt(input int c);
        int lo = (c == 1) ? 600 : ((c >= 2) ? 300 : 150);
        int hi = (c == 1) ? 90 : 190;
        wr(`WIC_OFS_FILTER, c << 4);
        tmr <= (c == 2) ? 2'b10 : ((c == 3) ? 2'b01 : 2'b00);
        lvl[2] <= ~lvl[2];
        repeat (lo) @(posedge SYS_CLK);
        rd(`WIC_OFS_LEVEL);
        if (c >= 2) tmr <= tmr ^ 2'b11;
        repeat (hi) @(posedge SYS_CLK);
        m_lvl ^= 4;
        m_st |= 4;
        rd(`WIC_OFS_LEVEL);
        rd(`WIC_OFS_STATUS);
        outs();
        wr(`WIC_OFS_STATUS, 4);
        outs();
        tmr <= 2'b00;
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        void'($urandom(54));
        repeat (20) @(posedge SYS_CLK);
        NRST <= 1'b1;
        outs();
        for (int a = 0; a < 32; a += 4) rd(5'(a));
        $display("test reset done");
        lvl <= 3'($urandom);
        repeat (700) @(posedge SYS_CLK);
        m_lvl = lvl;
        for (int k = 0; k < 8; k++) begin
            wr(`WIC_OFS_PULL, (k % 4) | ($urandom & 60));
            outs();
        end
        wr(`WIC_OFS_PULL, 'h3F);
        lvl <= ~lvl;
        repeat (700) @(posedge SYS_CLK);
        m_lvl = lvl;
        rd(`WIC_OFS_LEVEL);
        outs();
        $display("test pull done");
        wr(`WIC_OFS_WAKE_EN, 4);
        wr(`WIC_OFS_MASK, 4);
        for (int c = 0; c < 4; c++) flt(c);
        $display("test filter done");
        wr(`WIC_OFS_PULL, 'h3A);
        wr(`WIC_OFS_WAKE_EN, 3);
        wr(`WIC_OFS_MEAS, 1);
        outs();
        wr(`WIC_OFS_PULL, 'h39);
        rd(`WIC_OFS_PULL);
        lvl[0] <= ~lvl[0];
        repeat (200) @(posedge SYS_CLK);
        rd(`WIC_OFS_LEVEL);
        rd(`WIC_OFS_STATUS);
        wr(`WIC_OFS_MODE, 1);
        outs();
        wr(`WIC_OFS_MODE, 0);
        outs();
        wr(`WIC_OFS_MODE, 2);
        rd(`WIC_OFS_MODE);
        rd(`WIC_OFS_STATUS);
        wr(`WIC_OFS_STATUS, 8);
        wr(`WIC_OFS_MODE, 0);
        wr(`WIC_OFS_MEAS, 0);
        outs();
        repeat (200) @(posedge SYS_CLK);
        m_lvl ^= 1;
        m_st |= 1;
        rd(`WIC_OFS_LEVEL);
        rd(`WIC_OFS_STATUS);
        outs();
        wr(`WIC_OFS_MODE, 2);
        lvl[0] <= ~lvl[0];
        repeat (200) @(posedge SYS_CLK);
        m_lvl ^= 1;
        m_mode = 0;
        rd(`WIC_OFS_MODE);
        rd(`WIC_OFS_LEVEL);
        $display("test measure done");
        final_report();
    end
    // Whole run is near 5000 cycles; give it six times that
    initial begin
        #3_000_000;
        failures++;
        final_report();
    end
endmodule // testbench
bind wic_core wic_checker i_chk (.SYS_CLK(SYS_CLK), .NRST(NRST), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .HV_IN(HV_IN), .PULL_UP_EN(PULL_UP_EN), .PULL_DOWN_EN(PULL_DOWN_EN),
    .SENSE_SWITCH_CLOSE(SENSE_SWITCH_CLOSE), .IRQ(IRQ));
